// ==== vio_pkg.sv ====
// Shared constants, configuration layouts and helpers for the loopback and output conditioner
package vio_pkg;

  // Internal status vector and selector width
  localparam int NSIG = 64;
  localparam int SELW = 6;
  localparam int FUNCW = 7;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_IN_NS = 1000000;
  localparam int TICK_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
  localparam logic [7:0] ONE_SHOT_MS = 8'hfa;
  localparam logic [7:0] DEAD_MAX_MS = 8'hfa;

  // Register byte offsets
  localparam logic [7:0] VIN_STATUS_OFS = 8'h00;
  localparam logic [7:0] DOUT_STATUS_OFS = 8'h04;
  localparam logic [7:0] VIN_CFG_BASE = 8'h10;
  localparam logic [7:0] DOUT_CFG_BASE = 8'h30;

  // Loopback config word fields
  localparam int VIN_SRC_LSB = 0;
  localparam int VIN_INV_BIT = 8;
  localparam int VIN_SHOT_BIT = 9;
  localparam int VIN_DEAD_LSB = 16;
  localparam int VIN_FUNC_LSB = 24;
  localparam logic [31:0] VIN_WMASK = 32'h7fff033f;

  // Direct output config word fields
  localparam int DOUT_SEL_LSB = 0;
  localparam int DOUT_INV_BIT = 8;
  localparam int DOUT_OR_BIT = 9;
  localparam int DOUT_CINV_BIT = 10;
  localparam int DOUT_CEN_BIT = 11;
  localparam int DOUT_CSEL_LSB = 16;
  localparam int DOUT_OFF_LSB = 24;
  localparam logic [31:0] DOUT_WMASK = 32'hff3f0f3f;

  // Reset values of config words
  localparam logic [31:0] CFG_RESET = 32'h00000000;

  // Input function numbers and status indices
  localparam logic [FUNCW-1:0] FUNC_NONE = 7'h00;
  localparam logic [FUNCW-1:0] FUNC_STOP = 7'h12;
  localparam logic [SELW-1:0] TORQUE_LIMIT_IDX = 6'h23;

  typedef struct packed {
    logic [FUNCW-1:0] func;
    logic [7:0] deadMs;
    logic oneShot;
    logic invert;
    logic [SELW-1:0] src;
  } vio_vin_cfg_t;

  typedef struct packed {
    logic [7:0] offMs;
    logic [SELW-1:0] compSel;
    logic compEn;
    logic compInv;
    logic orMode;
    logic invert;
    logic [SELW-1:0] sel;
  } vio_dout_cfg_t;

  // Pick one status bit by selector
  function automatic logic pickBit(input logic [NSIG-1:0] v, input logic [SELW-1:0] i);
    pickBit = v[i];
  endfunction

  function automatic vio_vin_cfg_t toVinCfg(input logic [31:0] w);
    toVinCfg.func = w[VIN_FUNC_LSB +: FUNCW];
    toVinCfg.deadMs = w[VIN_DEAD_LSB +: 8];
    toVinCfg.oneShot = w[VIN_SHOT_BIT];
    toVinCfg.invert = w[VIN_INV_BIT];
    toVinCfg.src = w[VIN_SRC_LSB +: SELW];
  endfunction

  function automatic vio_dout_cfg_t toDoutCfg(input logic [31:0] w);
    toDoutCfg.offMs = w[DOUT_OFF_LSB +: 8];
    toDoutCfg.compSel = w[DOUT_CSEL_LSB +: SELW];
    toDoutCfg.compEn = w[DOUT_CEN_BIT];
    toDoutCfg.compInv = w[DOUT_CINV_BIT];
    toDoutCfg.orMode = w[DOUT_OR_BIT];
    toDoutCfg.invert = w[DOUT_INV_BIT];
    toDoutCfg.sel = w[DOUT_SEL_LSB +: SELW];
  endfunction

endpackage

// ==== vio_vin_chan.sv ====
// One internal loopback input: source pick, inversion, ON dead-time, one-shot
`timescale 1ns/1ps
module vio_vin_chan (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic msTick,
  // Status and settings
  input wire logic [vio_pkg::NSIG-1:0] statusIn,
  input wire vio_pkg::vio_vin_cfg_t cfg,
  // Conditioned line
  output logic loopOn_r
);

  logic srcLvl;
  logic armed;
  logic [7:0] holdMs_r;
  logic [7:0] shotMs_r;
  logic fired_r;

  // Selected status, optionally inverted
  assign srcLvl = vio_pkg::pickBit(statusIn, cfg.src) ^ cfg.invert;

  // Active time in whole ms ticks; saturates so long holds stay armed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      holdMs_r <= 8'h00;
    end else if (!srcLvl) begin
      holdMs_r <= 8'h00;
    end else if (msTick && holdMs_r != 8'hff) begin
      holdMs_r <= holdMs_r + 8'h01;
    end
  end

  // First tick is partial, so the count must pass the setting; saturation still arms
  assign armed = srcLvl && (cfg.deadMs == 8'h00 || holdMs_r > cfg.deadMs ||
                            holdMs_r == 8'hff);

  // One-shot timer restarts only after the source drops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shotMs_r <= 8'h00;
      fired_r <= 1'b0;
    end else if (!armed || !cfg.oneShot) begin
      shotMs_r <= 8'h00;
      fired_r <= 1'b0;
    end else if (msTick && !fired_r) begin
      shotMs_r <= shotMs_r + 8'h01;
      if (shotMs_r == vio_pkg::ONE_SHOT_MS - 8'h01) begin
        fired_r <= 1'b1;
      end
    end
  end

  // Line follows the armed level unless the shot has expired
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loopOn_r <= 1'b0;
    end else begin
      loopOn_r <= armed && !(cfg.oneShot && fired_r);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  dead_hold_a: assert property (!srcLvl |=> !loopOn_r)
    else $error("loopback line on with source inactive");
  shot_end_a: assert property (cfg.oneShot && fired_r && srcLvl |=> !loopOn_r)
    else $error("one-shot line not dropped");
  follow_a: assert property (!cfg.oneShot && srcLvl && cfg.deadMs == 8'h00 |=> loopOn_r)
    else $error("line not following source");

endmodule // vio_vin_chan

// ==== vio_dout_chan.sv ====
// One direct output: normal and composite pick, inversion, AND/OR, OFF delay
`timescale 1ns/1ps
module vio_dout_chan (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic msTick,
  // Status and settings
  input wire logic [vio_pkg::NSIG-1:0] statusIn,
  input wire vio_pkg::vio_dout_cfg_t cfg,
  // Connector drive
  output logic pinOn_r
);

  logic normLvl;
  logic compLvl;
  logic comb;
  logic [7:0] offCnt_r;

  // Normal and composite levels, each with its own inversion
  assign normLvl = vio_pkg::pickBit(statusIn, cfg.sel) ^ cfg.invert;
  assign compLvl = vio_pkg::pickBit(statusIn, cfg.compSel) ^ cfg.compInv;
  // Without the composite enabled the normal signal passes alone
  assign comb = !cfg.compEn ? normLvl :
                cfg.orMode ? (normLvl | compLvl) : (normLvl & compLvl);

  // Inactive time in ms ticks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      offCnt_r <= 8'h00;
    end else if (comb) begin
      offCnt_r <= 8'h00;
    end else if (msTick && offCnt_r != 8'hff) begin
      offCnt_r <= offCnt_r + 8'h01;
    end
  end

  // Turn on at once; first tick is partial, so hold until the count passes the delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinOn_r <= 1'b0;
    end else begin
      pinOn_r <= comb || (pinOn_r && cfg.offMs != 8'h00 && offCnt_r != 8'hff &&
                          offCnt_r <= cfg.offMs);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  on_follow_a: assert property (comb |=> pinOn_r)
    else $error("output not on while combination holds");
  off_zero_a: assert property (!comb && cfg.offMs == 8'h00 |=> !pinOn_r)
    else $error("output held with zero OFF delay");
  and_gate_a: assert property (cfg.compEn && !cfg.orMode && !compLvl && cfg.offMs == 8'h00
                               |=> !pinOn_r)
    else $error("AND mode passed with composite false");

endmodule // vio_dout_chan

// ==== vio_cond.sv ====
// Top of the loopback input and direct output conditioner with Avalon-MM registers
// How it works
// - Each loopback input picks its trigger from internal status signals.
// - Loopback line is on while its source is on, routed to its input function.
// - Per-line invert setting swaps the loopback signal's on/off sense.
// - Line turns on only after source stays on past the dead-time.
// - One-shot mode drops an on line after 250 ms.
// - One-shot is per line; off means the line just follows its source.
// - Each direct output picks which internal signal drives it.
// - Direct output stays on until its OFF delay has elapsed.
// - Each direct output may pick a second, composite signal.
// - Per-output setting combines normal and composite by AND or OR.
// - Output is on while that combination holds, then stays on for its OFF delay.
// - Composite signal has its own invert before the combination.
// - Torque-limit source into stop function stops the motor at limit.
`timescale 1ns/1ps
module vio_cond #(
  parameter int NVIN = 4,
  parameter int NDOUT = 6,
  parameter int NFUNC = 128,
  parameter int TICK_CYCLES = vio_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Internal output status signals
  input wire logic [vio_pkg::NSIG-1:0] statusIn,
  // Loopback lines and input functions they assert
  output logic [NVIN-1:0] loopInput,
  output logic [NFUNC-1:0] inputFunc,
  output logic stopRequest,
  // Connector outputs
  output logic [NDOUT-1:0] doutPin
);

  logic [31:0] vinWord_r [NVIN];
  logic [31:0] doutWord_r [NDOUT];
  vio_pkg::vio_vin_cfg_t vinCfg [NVIN];
  vio_pkg::vio_dout_cfg_t doutCfg [NDOUT];
  logic [31:0] tickCnt_r;
  logic msTick_r;
  logic req;
  logic accept;
  logic [31:0] rdNxt;
  logic [NFUNC-1:0] funcNxt;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    mergeBe = ((wd & m) | (old & ~m)) & mask;
  endfunction

  // Config register index decoders
  function automatic logic isVin(input logic [7:0] a, input int i);
    isVin = (a == vio_pkg::VIN_CFG_BASE + 8'(4 * i));
  endfunction

  function automatic logic isDout(input logic [7:0] a, input int i);
    isDout = (a == vio_pkg::DOUT_CFG_BASE + 8'(4 * i));
  endfunction

  // Millisecond enable; one clock, slower rates are single-cycle pulses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= 32'h00000000;
      msTick_r <= 1'b0;
    end else if (tickCnt_r == 32'(TICK_CYCLES - 1)) begin
      tickCnt_r <= 32'h00000000;
      msTick_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h00000001;
      msTick_r <= 1'b0;
    end
  end

  // Bus handshake: one wait cycle, then the access completes
  assign req = avs_read || avs_write;
  assign accept = req && !avs_waitrequest;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  // Read decode; unmapped addresses read as zero
  always_comb begin
    rdNxt = 32'h00000000;
    if (avs_address == vio_pkg::VIN_STATUS_OFS) begin
      rdNxt = 32'(loopInput);
    end else if (avs_address == vio_pkg::DOUT_STATUS_OFS) begin
      rdNxt = 32'(doutPin);
    end else begin
      for (int i = 0; i < NVIN; i++) begin
        if (isVin(avs_address, i)) begin
          rdNxt = vinWord_r[i];
        end
      end
      for (int j = 0; j < NDOUT; j++) begin
        if (isDout(avs_address, j)) begin
          rdNxt = doutWord_r[j];
        end
      end
    end
  end

  // Read data captured as waitrequest falls, so it stands at the accept edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdNxt;
    end
  end

  // Loopback config words; writes land only at the accept edge
  for (genvar gi = 0; gi < NVIN; gi++) begin : g_vin
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        vinWord_r[gi] <= vio_pkg::CFG_RESET;
      end else if (accept && avs_write && isVin(avs_address, gi)) begin
        vinWord_r[gi] <= mergeBe(vinWord_r[gi], avs_writedata, avs_byteenable,
                                 vio_pkg::VIN_WMASK);
      end
    end

    assign vinCfg[gi] = vio_pkg::toVinCfg(vinWord_r[gi]);

    vio_vin_chan u_vin (
      .clock(clock),
      .rst_n(rst_n),
      .msTick(msTick_r),
      .statusIn(statusIn),
      .cfg(vinCfg[gi]),
      .loopOn_r(loopInput[gi])
    );
  end

  // Direct output config words
  for (genvar go = 0; go < NDOUT; go++) begin : g_dout
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        doutWord_r[go] <= vio_pkg::CFG_RESET;
      end else if (accept && avs_write && isDout(avs_address, go)) begin
        doutWord_r[go] <= mergeBe(doutWord_r[go], avs_writedata, avs_byteenable,
                                  vio_pkg::DOUT_WMASK);
      end
    end

    assign doutCfg[go] = vio_pkg::toDoutCfg(doutWord_r[go]);

    vio_dout_chan u_dout (
      .clock(clock),
      .rst_n(rst_n),
      .msTick(msTick_r),
      .statusIn(statusIn),
      .cfg(doutCfg[go]),
      .pinOn_r(doutPin[go])
    );
  end

  // Route each active line to its input function; function 0 means unassigned
  always_comb begin
    funcNxt = '0;
    for (int k = 0; k < NVIN; k++) begin
      if (loopInput[k] && vinCfg[k].func != vio_pkg::FUNC_NONE) begin
        funcNxt[vinCfg[k].func] = 1'b1;
      end
    end
  end

  // Registered so the function bus never glitches into the motion logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inputFunc <= '0;
      stopRequest <= 1'b0;
    end else begin
      inputFunc <= funcNxt;
      stopRequest <= funcNxt[vio_pkg::FUNC_STOP];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Helper: line 0 is set for torque limit into stop, with no shaping
  logic tlStop;
  assign tlStop = vinCfg[0].src == vio_pkg::TORQUE_LIMIT_IDX && !vinCfg[0].invert &&
                  vinCfg[0].func == vio_pkg::FUNC_STOP && vinCfg[0].deadMs == 8'h00 &&
                  !vinCfg[0].oneShot;

  sequence limitHit_s;
    tlStop && statusIn[vio_pkg::TORQUE_LIMIT_IDX];
  endsequence

  sequence stopSeen_s;
    ##2 stopRequest;
  endsequence

  torque_stop_a: assert property (limitHit_s [*2] |-> stopSeen_s)
    else $error("torque limit did not raise stop");

  func_route_a: assert property (loopInput[0] && vinCfg[0].func != vio_pkg::FUNC_NONE
                                 |=> inputFunc[$past(vinCfg[0].func)])
    else $error("loopback line not routed to its function");

  wait_one_a: assert property (req && avs_waitrequest ##1 req |-> !avs_waitrequest ##1
                               avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  cfg_write_a: assert property (accept && avs_write && isVin(avs_address, 0) &&
                                avs_byteenable == 4'hf
                                |=> vinWord_r[0] == ($past(avs_writedata) &
                                vio_pkg::VIN_WMASK))
    else $error("loopback config write lost");

  // Output config writes land masked as well
  dout_write_a: assert property (accept && avs_write && isDout(avs_address, 0) &&
                                 avs_byteenable == 4'hf
                                 |=> doutWord_r[0] == ($past(avs_writedata) &
                                 vio_pkg::DOUT_WMASK))
    else $error("output config write lost");

  // A write still waiting must leave the config words alone
  wr_wait_a: assert property (avs_write && avs_waitrequest
                              |=> $stable(vinWord_r[0]) && $stable(doutWord_r[0]))
    else $error("config word changed during wait cycle");

  // Tick fires only at the counter wrap, so every timer sees whole periods
  tick_wrap_a: assert property (msTick_r |-> tickCnt_r == 32'h00000000)
    else $error("ms tick away from counter wrap");

  // Counter never passes its period, or a tick would be lost
  tick_range_a: assert property (tickCnt_r < 32'(TICK_CYCLES))
    else $error("ms tick counter out of range");

  // Idle bus keeps waitrequest high, so a fresh request always sees one wait
  sequence busIdle_s;
    !req;
  endsequence

  wait_idle_a: assert property (busIdle_s |=> avs_waitrequest)
    else $error("waitrequest low with no request");

  // Waitrequest is low for exactly one cycle per access
  wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles running");

  // Read data taken in the wait cycle stands at the accept edge
  sequence rdStart_s;
    avs_read && avs_waitrequest;
  endsequence

  rd_capture_a: assert property (rdStart_s |=> avs_readdata == $past(rdNxt))
    else $error("read data not captured in wait cycle");

  // Read data hold between reads; a slow master may sample late
  rd_hold_a: assert property (!(avs_read && avs_waitrequest)
                              |=> $stable(avs_readdata))
    else $error("read data moved without a read");

  // Status reads return the registered line and pin levels
  rd_lines_a: assert property (avs_read && avs_waitrequest &&
                               avs_address == vio_pkg::VIN_STATUS_OFS
                               |=> avs_readdata == 32'($past(loopInput)))
    else $error("loopback status read wrong");

  rd_pins_a: assert property (avs_read && avs_waitrequest &&
                              avs_address == vio_pkg::DOUT_STATUS_OFS
                              |=> avs_readdata == 32'($past(doutPin)))
    else $error("output status read wrong");

  // Config reads give back the stored word
  rd_cfg_a: assert property (avs_read && avs_waitrequest && isVin(avs_address, 0)
                             |=> avs_readdata == $past(vinWord_r[0]))
    else $error("loopback config read wrong");

  // Function 0 means unassigned and must never be driven
  func_none_a: assert property (!inputFunc[vio_pkg::FUNC_NONE])
    else $error("unassigned function raised");

  // Stop output is the stop bit of the function bus, never a separate path
  stop_copy_a: assert property (stopRequest == inputFunc[vio_pkg::FUNC_STOP])
    else $error("stop request differs from stop function");

  // With every line off the function bus clears a cycle later
  func_off_a: assert property (loopInput == '0 |=> inputFunc == '0)
    else $error("function bus set with all lines off");

  // Stop can only come from a line that is on
  stop_src_a: assert property (!(|loopInput) |=> !stopRequest)
    else $error("stop raised with every loopback line off");

  // Every active line reaches its function, not only line 0
  for (genvar ga = 0; ga < NVIN; ga++) begin : g_route_chk
    line_route_a: assert property (loopInput[ga] &&
                                   vinCfg[ga].func != vio_pkg::FUNC_NONE
                                   |=> inputFunc[$past(vinCfg[ga].func)])
      else $error("loopback line not routed to its function");
  end

endmodule // vio_cond

// ==== vio_cond_partner.sv ====
// Connector-side equipment model that watches direct output pin 1
`timescale 1ns/1ps
module vio_cond_partner #(
  parameter int NDOUT = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Connector pins
  input wire logic [NDOUT-1:0] doutPin,
  // Observed activity
  output logic [7:0] riseCount
);
  logic lastPin_r;

  // Count turn-on events of pin 1; a stretched pulse must not count twice
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lastPin_r <= 1'b0;
      riseCount <= 8'h00;
    end else begin
      lastPin_r <= doutPin[1];
      if (doutPin[1] && !lastPin_r) begin
        riseCount <= riseCount + 8'h01;
      end
    end
  end
endmodule // vio_cond_partner

// ==== vio_cond_tb.sv ====
// Self-checking testbench for the loopback input and direct output conditioner
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module vio_cond_tb;
  localparam int TK = 4;
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address, riseCount;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [63:0] statusIn;
  logic [3:0] loopInput;
  logic [127:0] inputFunc;
  logic stopRequest;
  logic [5:0] doutPin;
  int mismatches = 0;
  int num_checks = 0;

  // Short tick keeps the one-shot run near a thousand cycles
  vio_cond #(.TICK_CYCLES(TK)) dut (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .statusIn(statusIn), .loopInput(loopInput), .inputFunc(inputFunc),
    .stopRequest(stopRequest), .doutPin(doutPin));
  vio_cond_partner partner (.clock(clock), .rst_n(rst_n), .doutPin(doutPin),
    .riseCount(riseCount));

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One bus access held until waitrequest is seen low
  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      mismatches++;
      results();
    end
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    busXfer(1'b0, a, 32'h00000000, q);
    `CHK(nm, e, q)
  endtask

  task automatic setSt(input int i, input logic v);
    @(posedge clock);
    statusIn[i] <= v;
  endtask

  // Reset values, write mask, lane merge and an unmapped place
  task automatic tRegs;
    `CHK("waitIdle", 1'b1, avs_waitrequest)
    `CHK("pinsRst", 6'h00, doutPin)
    rdChk("vinRst", 8'h10, 32'h00000000);
    rdChk("doutRst", 8'h44, 32'h00000000);
    wrReg(8'h1c, 32'hffffffff);
    rdChk("vinMask", 8'h1c, vio_pkg::VIN_WMASK);
    avs_byteenable <= 4'h1;
    wrReg(8'h1c, 32'h00000000);
    avs_byteenable <= 4'hf;
    rdChk("laneMerge", 8'h1c, 32'h7fff0300);
    wrReg(8'h1c, 32'h00000000);
    wrReg(8'h50, 32'hffffffff);
    rdChk("unmapped", 8'h50, 32'h00000000);
  endtask

  // Torque-limit status drives the stop function
  task automatic tStop;
    wrReg(8'h10, 32'h12000023);
    setSt(35, 1'b1);
    cyc(1);
    `CHK("loop0", 1'b1, loopInput[0])
    cyc(1);
    `CHK("stopReq", 1'b1, stopRequest)
    `CHK("func18", 1'b1, inputFunc[18])
    `CHK("funcOnly", 128'h1 << 18, inputFunc)
    setSt(35, 1'b0);
    cyc(3);
    `CHK("stopOff", 1'b0, stopRequest)
  endtask

  // Inverted source is on while the status is off
  task automatic tInv;
    wrReg(8'h14, 32'h00000105);
    cyc(2);
    `CHK("invOn", 1'b1, loopInput[1])
    `CHK("noFunc", 128'h0, inputFunc)
    setSt(5, 1'b1);
    cyc(2);
    `CHK("invOff", 1'b0, loopInput[1])
    setSt(5, 1'b0);
  endtask

  // Three tick dead-time delays the turn-on
  task automatic tDead;
    wrReg(8'h18, 32'h00030007);
    setSt(7, 1'b1);
    cyc(7);
    `CHK("deadLow", 1'b0, loopInput[2])
    cyc(12);
    `CHK("deadHigh", 1'b1, loopInput[2])
    setSt(7, 1'b0);
    cyc(2);
    `CHK("deadDrop", 1'b0, loopInput[2])
  endtask

  // One-shot drops after 250 ticks; a plain line stays on
  task automatic tShot;
    wrReg(8'h1c, 32'h00000209);
    setSt(9, 1'b1);
    cyc(2);
    `CHK("shotOn", 1'b1, loopInput[3])
    cyc(240 * TK);
    `CHK("shotHeld", 1'b1, loopInput[3])
    cyc(20 * TK);
    `CHK("shotOff", 1'b0, loopInput[3])
    `CHK("plainOn", 1'b1, loopInput[1])
    rdChk("loopReg", 8'h00, 32'h00000002);
    setSt(9, 1'b0);
  endtask

  // Every invert, composite invert and AND/OR mode against all inputs
  task automatic tDout;
    logic [4:0] b;
    logic e;
    for (int i = 0; i < 32; i++) begin
      b = i[4:0];
      wrReg(8'h30, 32'h000b080a | {21'h0, b[2:0], 8'h00});
      @(posedge clock);
      statusIn[10] <= b[3];
      statusIn[11] <= b[4];
      cyc(3);
      e = b[1] ? ((b[3] ^ b[0]) | (b[4] ^ b[2])) : ((b[3] ^ b[0]) & (b[4] ^ b[2]));
      `CHK("pinComb", e, doutPin[0])
    end
    rdChk("pinReg", 8'h04, {31'h0, e});
  endtask

  // Two tick OFF delay stretches the pin
  task automatic tOff;
    wrReg(8'h34, 32'h0200000c);
    setSt(12, 1'b1);
    cyc(3);
    `CHK("offOn", 1'b1, doutPin[1])
    setSt(12, 1'b0);
    cyc(2);
    `CHK("offHeld", 1'b1, doutPin[1])
    cyc(12);
    `CHK("offDone", 1'b0, doutPin[1])
    `CHK("riseOnce", 8'h01, riseCount)
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    statusIn = 64'h0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    cyc(1);
    tRegs();
    tStop();
    tInv();
    tDead();
    tShot();
    tDout();
    tOff();
    results();
  end
endmodule // vio_cond_tb
